// [hw/coad_map.vh]
// constants for the operand address decoder
`ifndef COAD_MAP_VH
`define COAD_MAP_VH
// addressing modes (17)
`define COAD_M_INH      5'h00
`define COAD_M_IMM      5'h01
`define COAD_M_DIR_S    5'h02
`define COAD_M_DIR_L    5'h03
`define COAD_M_IDX_0    5'h04
`define COAD_M_IDX_S    5'h05
`define COAD_M_IDX_L    5'h06
`define COAD_M_IND_S    5'h07
`define COAD_M_IND_L    5'h08
`define COAD_M_IIX_S    5'h09
`define COAD_M_IIX_L    5'h0A
`define COAD_M_REL_D    5'h0B
`define COAD_M_REL_I    5'h0C
`define COAD_M_BIT_D    5'h0D
`define COAD_M_BIT_I    5'h0E
`define COAD_M_BTR_D    5'h0F
`define COAD_M_BTR_I    5'h10
// mode families (7)
`define COAD_F_INH      3'h0
`define COAD_F_IMM      3'h1
`define COAD_F_DIR      3'h2
`define COAD_F_IDX      3'h3
`define COAD_F_IND      3'h4
`define COAD_F_REL      3'h5
`define COAD_F_BIT      3'h6
// prefix bytes
`define COAD_PFX_Y      8'h90
`define COAD_PFX_IND    8'h92
`define COAD_PFX_YIND   8'h91
// reset values and page-zero mask
`define COAD_RST_ADDR   16'h0000
`define COAD_RST_BYTE   8'h00
`define COAD_PAGE0_MASK 16'h00FF
`endif

// [hw/coad_mode_dec.v]
// opcode and prefix to addressing mode decoder
`timescale 1ns/1ps
`include "coad_map.vh"
module coad_mode_dec (
  input  wire [7:0] opcode,     // opcode byte
  input  wire [1:0] pfx,        // 0 none, 1 y, 2 indirect, 3 y indirect
  output reg  [4:0] mode,       // decoded addressing mode
  output reg        use_y,      // index y instead of x
  output reg        rmw_op,     // read-modify-write class
  output reg  [2:0] bit_num     // bit number for bit forms
);
  // opcode column: high nibble selects form, low nibble the operation
  always @* begin
    use_y   = (pfx == 2'h1) || (pfx == 2'h3);
    bit_num = opcode[3:1];
    rmw_op  = 1'b0;
    mode    = `COAD_M_INH;
    case (opcode[7:4])
      4'h0: mode = (pfx == 2'h2) ? `COAD_M_BTR_I : `COAD_M_BTR_D;
      4'h1: mode = (pfx == 2'h2) ? `COAD_M_BIT_I : `COAD_M_BIT_D;
      4'h2: mode = (pfx == 2'h2) ? `COAD_M_REL_I : `COAD_M_REL_D;
      4'h3: begin
        rmw_op = 1'b1;
        mode   = (pfx == 2'h2) ? `COAD_M_IND_S : `COAD_M_DIR_S;
      end
      4'h4, 4'h5, 4'h8, 4'h9: mode = `COAD_M_INH;
      4'h6: begin
        rmw_op = 1'b1;
        mode   = pfx[1] ? `COAD_M_IIX_S : `COAD_M_IDX_S;
      end
      4'h7: begin
        rmw_op = 1'b1;
        mode   = `COAD_M_IDX_0;
      end
      4'hA: mode = `COAD_M_IMM;
      4'hB: mode = (pfx == 2'h2) ? `COAD_M_IND_S : `COAD_M_DIR_S;
      4'hC: mode = (pfx == 2'h2) ? `COAD_M_IND_L : `COAD_M_DIR_L;
      4'hD: mode = pfx[1] ? `COAD_M_IIX_L : `COAD_M_IDX_L;
      4'hE: mode = pfx[1] ? `COAD_M_IIX_S : `COAD_M_IDX_S;
      4'hF: mode = `COAD_M_IDX_0;
      default: mode = `COAD_M_INH;
    endcase
  end
endmodule

// [hw/coad_addr_add.v]
// unsigned index add and signed relative add
`timescale 1ns/1ps
module coad_addr_add (
  input  wire [15:0] base,      // offset, pointer or pc
  input  wire [7:0]  index,     // index register value
  input  wire        rel,       // add signed byte instead of index
  input  wire [7:0]  rel_off,   // signed branch offset
  output wire [15:0] sum        // resulting address
);
  wire [15:0] ext_idx;
  wire [15:0] ext_rel;
  assign ext_idx = {8'h00, index};
  assign ext_rel = {{8{rel_off[7]}}, rel_off};
  assign sum     = base + (rel ? ext_rel : ext_idx);
endmodule

// [hw/coad_top.v]
// operand addressing logic: mode decode, operand fetch, address forming
`timescale 1ns/1ps
`include "coad_map.vh"
// Notes on behaviour
// - seventeen addressing modes in seven families are decoded.
// - inherent instructions are one byte and fetch no operand.
// - immediate instructions take the next byte as the operand value.
// - short direct fetches one address byte reaching 00 to FF.
// - long direct fetches a two-byte address reaching all 64 Kbyte.
// - indexed address is the unsigned sum of index register and offset.
// - indexed without offset uses the index alone, one extra byte with y.
// - short indexed adds one offset byte unsigned, reaching up to 1FE.
// - short direct and short indirect forms reach page zero, and read-modify-write ops take short forms only.
// - relative branches add a signed byte to the pc of the next instruction.
// - long indexed adds a two-byte offset to the index register.
// - short indirect reads a one-byte pointer from page zero.
// - long indirect reads a two-byte pointer from page zero.
// - prefix 90 selects y, 92 selects indirect, 91 selects y indirect.
module coad_top (
  input  wire        mclk,       // core clock
  input  wire        sys_rst,    // synchronous reset, active high
  input  wire        clk_en,     // freezes all state when low
  input  wire        fetch_vld,  // fetch byte valid this cycle
  input  wire [7:0]  fetch_byte, // next instruction byte
  input  wire [15:0] pc_in,      // address of fetch_byte
  input  wire [7:0]  x_reg,      // index register x
  input  wire [7:0]  y_reg,      // index register y
  input  wire        mem_ack,    // pointer read data valid
  input  wire [7:0]  mem_rdata,  // pointer read data
  output reg         mem_rd,     // pointer read request
  output reg  [15:0] mem_addr,   // pointer read address
  output reg         done,       // one-cycle pulse: result valid
  output reg  [4:0]  mode_out,   // decoded addressing mode
  output reg  [2:0]  family_out, // mode family
  output reg  [15:0] ea_out,     // effective address or branch target
  output reg  [7:0]  imm_out,    // immediate operand value
  output reg         imm_vld,    // operand is immediate
  output reg  [2:0]  bit_out,    // bit number for bit forms
  output reg  [15:0] br_tgt,     // branch target of bit-test-and-branch
  output reg  [1:0]  len_out,    // operand bytes after the opcode
  output reg         form_err    // read-modify-write with a long form
);
  localparam S_OPC  = 3'h0;
  localparam S_OP1  = 3'h1;
  localparam S_OP2  = 3'h2;
  localparam S_PTR1 = 3'h3;
  localparam S_PTR2 = 3'h4;
  localparam S_DONE = 3'h5;

  reg [2:0]  st_reg;
  reg [1:0]  pfx_reg;
  reg [7:0]  opc_reg;
  reg [7:0]  b1_reg;
  reg [7:0]  b2_reg;
  reg [7:0]  p_hi_reg;
  reg [1:0]  cnt_reg;
  reg        ptr_long_reg;
  // pc_in moves on before a pointer read ends, so the pc past the address byte is kept
  reg [15:0] pc_nxt_reg;

  wire [4:0] mode;
  wire       use_y;
  wire       rmw_op;
  wire [2:0] bit_num;
  wire [7:0] idx;
  wire [15:0] idx_sum;
  wire [15:0] rel_sum;
  reg  [15:0] add_base;

  coad_mode_dec u_dec (
    .opcode  (opc_reg),
    .pfx     (pfx_reg),
    .mode    (mode),
    .use_y   (use_y),
    .rmw_op  (rmw_op),
    .bit_num (bit_num)
  );

  assign idx = use_y ? y_reg : x_reg;

  coad_addr_add u_idx (
    .base    (add_base),
    .index   (idx),
    .rel     (1'b0),
    .rel_off (8'h00),
    .sum     (idx_sum)
  );

  // pc after the branch offset byte is the next instruction address
  coad_addr_add u_rel (
    .base    (pc_in + 16'h0001),
    .index   (8'h00),
    .rel     (1'b1),
    .rel_off (fetch_byte),
    .sum     (rel_sum)
  );

  // operand byte count after opcode, per mode
  function [1:0] op_len;
    input [4:0] m;
    begin
      case (m)
        `COAD_M_INH:   op_len = 2'h0;
        `COAD_M_IMM:   op_len = 2'h1;
        `COAD_M_DIR_S: op_len = 2'h1;
        `COAD_M_DIR_L: op_len = 2'h2;
        // the y form is one byte longer, but that byte is the prefix
        // ahead of the opcode; no operand follows the opcode either way
        `COAD_M_IDX_0: op_len = 2'h0;
        `COAD_M_IDX_S: op_len = 2'h1;
        `COAD_M_IDX_L: op_len = 2'h2;
        `COAD_M_IND_S, `COAD_M_IND_L,
        `COAD_M_IIX_S, `COAD_M_IIX_L: op_len = 2'h1;
        `COAD_M_REL_D, `COAD_M_REL_I: op_len = 2'h1;
        `COAD_M_BIT_D, `COAD_M_BIT_I: op_len = 2'h1;
        `COAD_M_BTR_D, `COAD_M_BTR_I: op_len = 2'h2;
        default:       op_len = 2'h0;
      endcase
    end
  endfunction

  // family of a mode
  function [2:0] fam;
    input [4:0] m;
    begin
      case (m)
        `COAD_M_INH: fam = `COAD_F_INH;
        `COAD_M_IMM: fam = `COAD_F_IMM;
        `COAD_M_DIR_S, `COAD_M_DIR_L: fam = `COAD_F_DIR;
        `COAD_M_IDX_0, `COAD_M_IDX_S, `COAD_M_IDX_L: fam = `COAD_F_IDX;
        `COAD_M_IND_S, `COAD_M_IND_L, `COAD_M_IIX_S, `COAD_M_IIX_L: fam = `COAD_F_IND;
        `COAD_M_REL_D, `COAD_M_REL_I: fam = `COAD_F_REL;
        default: fam = `COAD_F_BIT;
      endcase
    end
  endfunction

  // pointer-based modes need a page-zero read
  function is_ptr;
    input [4:0] m;
    begin
      is_ptr = (m == `COAD_M_IND_S) || (m == `COAD_M_IND_L) ||
               (m == `COAD_M_IIX_S) || (m == `COAD_M_IIX_L) ||
               (m == `COAD_M_REL_I) || (m == `COAD_M_BIT_I) ||
               (m == `COAD_M_BTR_I);
    end
  endfunction

  // one adder serves every indexed sum; only its base follows the mode
  always @* begin
    case (mode)
      `COAD_M_IDX_0: add_base = 16'h0000;
      `COAD_M_IDX_S: add_base = {8'h00, b1_reg};
      `COAD_M_IDX_L: add_base = {b1_reg, b2_reg};
      `COAD_M_IIX_S: add_base = {8'h00, mem_rdata};
      `COAD_M_IIX_L: add_base = {p_hi_reg, mem_rdata};
      default:       add_base = 16'h0000;
    endcase
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      st_reg       <= S_OPC;
      pfx_reg      <= 2'h0;
      opc_reg      <= `COAD_RST_BYTE;
      b1_reg       <= `COAD_RST_BYTE;
      b2_reg       <= `COAD_RST_BYTE;
      p_hi_reg     <= `COAD_RST_BYTE;
      cnt_reg      <= 2'h0;
      ptr_long_reg <= 1'b0;
      mem_rd       <= 1'b0;
      mem_addr     <= `COAD_RST_ADDR;
      done         <= 1'b0;
      mode_out     <= `COAD_M_INH;
      family_out   <= `COAD_F_INH;
      ea_out       <= `COAD_RST_ADDR;
      imm_out      <= `COAD_RST_BYTE;
      imm_vld      <= 1'b0;
      bit_out      <= 3'h0;
      br_tgt       <= `COAD_RST_ADDR;
      len_out      <= 2'h0;
      form_err     <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      case (st_reg)
        S_OPC: if (fetch_vld) begin
          // a prefix byte is latched, then the opcode follows
          if (fetch_byte == `COAD_PFX_Y) begin
            pfx_reg <= 2'h1;
          end else if (fetch_byte == `COAD_PFX_IND) begin
            pfx_reg <= 2'h2;
          end else if (fetch_byte == `COAD_PFX_YIND) begin
            pfx_reg <= 2'h3;
          end else begin
            opc_reg <= fetch_byte;
            cnt_reg <= 2'h0;
            st_reg  <= S_OP1;
          end
        end
        S_OP1: begin
          // decoder now sees opc_reg; count and collect operand bytes
          mode_out   <= mode;
          family_out <= fam(mode);
          bit_out    <= bit_num;
          len_out    <= op_len(mode);
          // short-only ops on long forms are flagged, yet still executed in the long form
          form_err   <= rmw_op && ((mode == `COAD_M_DIR_L) ||
                        (mode == `COAD_M_IDX_L) || (mode == `COAD_M_IND_L));
          if (op_len(mode) == 2'h0) begin
            ea_out  <= (mode == `COAD_M_IDX_0) ? idx_sum : `COAD_RST_ADDR;
            imm_vld <= 1'b0;
            st_reg  <= S_DONE;
          end else if (fetch_vld) begin
            if (cnt_reg == 2'h0) begin
              b1_reg <= fetch_byte;
              if (mode == `COAD_M_REL_D)
                ea_out <= rel_sum;
            end else begin
              b2_reg <= fetch_byte;
              br_tgt <= rel_sum;
            end
            if (cnt_reg + 2'h1 == op_len(mode))
              st_reg <= S_OP2;
            cnt_reg <= cnt_reg + 2'h1;
          end
        end
        S_OP2: begin
          imm_vld <= (mode == `COAD_M_IMM);
          imm_out <= b1_reg;
          st_reg  <= S_DONE;
          case (mode)
            `COAD_M_DIR_S, `COAD_M_BIT_D, `COAD_M_BTR_D:
              ea_out <= {8'h00, b1_reg} & `COAD_PAGE0_MASK;
            `COAD_M_DIR_L: ea_out <= {b1_reg, b2_reg};
            `COAD_M_IDX_0: ea_out <= idx_sum;
            `COAD_M_IDX_S, `COAD_M_IDX_L: ea_out <= idx_sum;
            `COAD_M_REL_D: ea_out <= ea_out;
            default: ea_out <= `COAD_RST_ADDR;
          endcase
          if (is_ptr(mode)) begin
            // pointer lives in page zero at the byte after the opcode
            mem_rd       <= 1'b1;
            mem_addr     <= {8'h00, b1_reg};
            ptr_long_reg <= (mode == `COAD_M_IND_L) || (mode == `COAD_M_IIX_L);
            st_reg       <= S_PTR1;
          end
        end
        // wait states simply hold the request; the address stays put meanwhile
        S_PTR1: if (mem_ack) begin
          if (ptr_long_reg) begin
            // high byte first, then the next page-zero byte
            p_hi_reg <= mem_rdata;
            mem_addr <= {8'h00, b1_reg + 8'h01};
            st_reg   <= S_PTR2;
          end else begin
            mem_rd <= 1'b0;
            st_reg <= S_DONE;
            case (mode)
              `COAD_M_IIX_S: ea_out <= idx_sum;
              `COAD_M_REL_I: ea_out <= rel_sum_i(mem_rdata);
              default:       ea_out <= {8'h00, mem_rdata};
            endcase
          end
        end
        S_PTR2: if (mem_ack) begin
          mem_rd <= 1'b0;
          st_reg <= S_DONE;
          if (mode == `COAD_M_IIX_L)
            ea_out <= idx_sum;
          else
            ea_out <= {p_hi_reg, mem_rdata};
        end
        S_DONE: begin
          // prefix lives until the result is out, so it never leaks into the next opcode
          done    <= 1'b1;
          pfx_reg <= 2'h0;
          st_reg  <= S_OPC;
        end
        default: st_reg <= S_OPC;
      endcase
    end
  end

  // indirect relative: offset from memory, pc is past the address byte
  function [15:0] rel_sum_i;
    input [7:0] off;
    begin
      rel_sum_i = pc_nxt_reg + {{8{off[7]}}, off};
    end
  endfunction

  // captured as the last operand byte goes by
  always @(posedge mclk) begin
    if (sys_rst)
      pc_nxt_reg <= `COAD_RST_ADDR;
    else if (clk_en && st_reg == S_OP1 && fetch_vld)
      pc_nxt_reg <= pc_in + 16'h0001;
  end
endmodule

// [tb/coad_top_props.sv]
// assertion checker for the operand address decoder
`timescale 1ns/1ps
`include "coad_map.vh"
module coad_top_props (
  input wire        mclk,       // core clock
  input wire        sys_rst,    // sync reset
  input wire        clk_en,     // state enable
  input wire        fetch_vld,  // fetch valid
  input wire [7:0]  fetch_byte, // fetch byte
  input wire [15:0] pc_in,      // fetch address
  input wire [7:0]  x_reg,      // index x
  input wire [7:0]  y_reg,      // index y
  input wire        mem_ack,    // pointer ack
  input wire [7:0]  mem_rdata,  // pointer data
  input wire        mem_rd,     // pointer request
  input wire [15:0] mem_addr,   // pointer address
  input wire        done,       // result pulse
  input wire [4:0]  mode_out,   // mode
  input wire [2:0]  family_out, // family
  input wire [15:0] ea_out,     // effective address
  input wire [7:0]  imm_out,    // immediate value
  input wire        imm_vld,    // immediate flag
  input wire [2:0]  bit_out,    // bit number
  input wire [15:0] br_tgt,     // branch target
  input wire [1:0]  len_out,    // operand bytes
  input wire        form_err    // bad form
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  mode_range_a: assert property (done |-> mode_out <= 5'h10 && family_out <= 3'h6)
    else $error("mode or family code out of range");
  inh_len_a: assert property (done && family_out == `COAD_F_INH |-> len_out == 2'h0)
    else $error("inherent form with operand bytes");
  imm_flag_a: assert property (done && mode_out == `COAD_M_IMM |-> imm_vld && len_out == 2'h1)
    else $error("immediate form wrong flag or length");
  dir_short_a: assert property (done && mode_out == `COAD_M_DIR_S |-> ea_out[15:8] == 8'h00)
    else $error("short direct left page zero");
  dir_long_a: assert property (done && mode_out == `COAD_M_DIR_L |-> len_out == 2'h2)
    else $error("long direct length wrong");
  idx_none_a: assert property (done && mode_out == `COAD_M_IDX_0 |-> ea_out[15:8] == 8'h00)
    else $error("indexed without offset left page zero");
  idx_short_a: assert property (done && mode_out == `COAD_M_IDX_S |-> ea_out <= 16'h01FE)
    else $error("short indexed beyond 1FE");
  idx_long_a: assert property (done && mode_out == `COAD_M_IDX_L |-> len_out == 2'h2)
    else $error("long indexed length wrong");
  ptr_page_a: assert property (mem_rd |-> mem_addr[15:8] == 8'h00)
    else $error("pointer read outside page zero");
  ptr_hold_a: assert property (mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr))
    else $error("pointer request dropped before ack");
endmodule

// [tb/coad_mem_model.sv]
// page-zero pointer memory: data is address xor A5, answered fast or slow
`timescale 1ns/1ps
module coad_mem_model (
  input  wire        mclk,      // core clock
  input  wire        sys_rst,   // sync reset
  input  wire        slow,      // add wait cycles
  input  wire        mem_rd,    // request
  input  wire [15:0] mem_addr,  // address
  output reg         mem_ack,   // one-cycle ack
  output reg  [7:0]  mem_rdata  // data, toggling garbage outside ack
);
  reg [2:0] wait_reg;
  always @(posedge mclk) begin
    if (sys_rst) begin
      mem_ack   <= 1'b0;
      wait_reg  <= 3'h0;
      mem_rdata <= 8'h5A;
    end else if (!mem_rd || mem_ack || wait_reg != 3'h0) begin
      mem_ack   <= 1'b0;
      wait_reg  <= (mem_rd && !mem_ack) ? wait_reg - 3'h1 : (slow ? 3'h4 : 3'h0);
      mem_rdata <= ~mem_rdata;
    end else begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem_addr[7:0] ^ 8'hA5;
    end
  end
endmodule

// [tb/cpu_operand_address_decoder_bench.sv]
// self-checking bench for the operand address decoder
`timescale 1ns/1ps
`include "coad_map.vh"
module cpu_operand_address_decoder_bench;
  reg         mclk, sys_rst, clk_en, fetch_vld, slow;
  reg  [7:0]  fetch_byte, x_reg, y_reg;
  reg  [15:0] pc_in, pc;
  wire        mem_ack, mem_rd, done, imm_vld, form_err;
  wire [7:0]  mem_rdata, imm_out;
  wire [15:0] mem_addr, ea_out, br_tgt;
  wire [4:0]  mode_out;
  wire [2:0]  family_out, bit_out;
  wire [1:0]  len_out;
  integer     n_errors, checks;
  coad_top dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .fetch_vld(fetch_vld),
    .fetch_byte(fetch_byte), .pc_in(pc_in), .x_reg(x_reg), .y_reg(y_reg), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .mem_rd(mem_rd), .mem_addr(mem_addr), .done(done),
    .mode_out(mode_out), .family_out(family_out), .ea_out(ea_out), .imm_out(imm_out),
    .imm_vld(imm_vld), .bit_out(bit_out), .br_tgt(br_tgt), .len_out(len_out),
    .form_err(form_err));
  coad_mem_model mem_i (.mclk(mclk), .sys_rst(sys_rst), .slow(slow), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
      end
    end
  endtask
  // sends n bytes from the top of w, one a cycle, then waits for done
  task run(input integer n, input [31:0] w);
    integer i;
    begin
      for (i = n - 1; i >= 0; i = i - 1) begin
        @(posedge mclk);
        fetch_vld  <= 1'b1;
        fetch_byte <= w[8*i +: 8];
        pc_in      <= pc;
        pc = pc + 16'h0001;
      end
      @(posedge mclk);
      fetch_vld <= 1'b0;
      i = 0;
      while (done !== 1'b1 && i < 40) begin
        @(posedge mclk);
        i = i + 1;
      end
      if (i == 40)
        chk(16'h0001, 16'h0000);
    end
  endtask
  task t_direct;
    begin
      run(1, 32'h40);
      chk({11'h000, mode_out}, {11'h000, `COAD_M_INH});
      chk({14'h0000, len_out}, 16'h0000);
      run(2, 32'hA155);
      chk({8'h00, imm_out}, 16'h0055);
      chk({15'h0000, imm_vld}, 16'h0001);
      run(2, 32'hB1FF);
      chk(ea_out, 16'h00FF);
      run(3, 32'hC1FFFE);
      chk(ea_out, 16'hFFFE);
      run(2, 32'h3180);
      chk({15'h0000, form_err}, 16'h0000);
    end
  endtask
  task t_index;
    begin
      run(1, 32'hF1);
      chk(ea_out, 16'h00FF);
      run(2, 32'hE1FF);
      chk(ea_out, 16'h01FE);
      run(3, 32'hD11200);
      chk(ea_out, 16'h12FF);
      run(2, 32'h90F1);
      chk(ea_out, 16'h0021);
      chk({14'h0000, len_out}, 16'h0000);
      run(3, 32'h90E1F0);
      chk(ea_out, 16'h0111);
    end
  endtask
  // pointer bytes read back as address xor A5
  task t_indirect;
    begin
      run(3, 32'h92B110);
      chk(ea_out, 16'h00B5);
      slow <= 1'b1;
      run(3, 32'h92C110);
      chk(ea_out, 16'hB5B4);
      x_reg <= 8'h05;
      run(3, 32'h92E110);
      chk(ea_out, 16'h00BA);
      run(3, 32'h92D110);
      chk(ea_out, 16'hB5B9);
      run(3, 32'h91E110);
      chk(ea_out, 16'h00D6);
      slow <= 1'b0;
    end
  endtask
  task t_branch;
    begin
      pc = 16'h0100;
      run(2, 32'h2180);
      chk(ea_out, 16'h0082);
      chk({13'h0000, family_out}, {13'h0000, `COAD_F_REL});
      run(2, 32'h217F);
      chk(ea_out, 16'h0183);
      run(2, 32'h1B40);
      chk({13'h0000, bit_out}, 16'h0005);
      chk({13'h0000, family_out}, {13'h0000, `COAD_F_BIT});
      pc = 16'h0200;
      run(3, 32'h070510);
      chk(br_tgt, 16'h0213);
      chk(ea_out, 16'h0005);
      // indirect forms: pointer at 10 reads back B5
      pc = 16'h0300;
      run(3, 32'h922110);
      chk(ea_out, 16'h02B8);
      chk({13'h0000, family_out}, {13'h0000, `COAD_F_REL});
      run(3, 32'h921B10);
      chk(ea_out, 16'h00B5);
      chk({11'h000, mode_out}, {11'h000, `COAD_M_BIT_I});
      pc = 16'h0400;
      run(4, 32'h92071020);
      chk(br_tgt, 16'h0424);
      chk(ea_out, 16'h00B5);
    end
  endtask
  // mid-run reset clears the results, then a transfer still works
  task t_reset;
    begin
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      chk(ea_out, `COAD_RST_ADDR);
      chk({11'h000, mode_out}, {11'h000, `COAD_M_INH});
      run(2, 32'hA155);
      chk({8'h00, imm_out}, 16'h0055);
    end
  endtask
  // with the enable low an offered opcode must leave no trace
  task t_hold;
    begin
      clk_en     <= 1'b0;
      fetch_vld  <= 1'b1;
      fetch_byte <= 8'h40;
      repeat (4) @(posedge mclk);
      clk_en    <= 1'b1;
      fetch_vld <= 1'b0;
      repeat (4) @(posedge mclk);
      chk({11'h000, mode_out}, {11'h000, `COAD_M_IMM});
      chk({15'h0000, imm_vld}, 16'h0001);
    end
  endtask
  task summarize;
    begin
      if (n_errors == 0 && checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // the whole run is a few hundred cycles; this allows ample slack
  initial begin
    #50000;
    n_errors = n_errors + 1;
    summarize;
  end
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    fetch_vld = 1'b0;
    fetch_byte = 8'h00;
    pc_in = 16'h0000;
    x_reg = 8'hFF;
    y_reg = 8'h21;
    slow = 1'b0;
    pc = 16'h0100;
    n_errors = 0;
    checks = 0;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    t_direct;
    t_index;
    t_indirect;
    t_branch;
    t_reset;
    t_hold;
    summarize;
  end
endmodule
bind coad_top coad_top_props chk_i (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
  .fetch_vld(fetch_vld), .fetch_byte(fetch_byte), .pc_in(pc_in), .x_reg(x_reg),
  .y_reg(y_reg), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_rd(mem_rd),
  .mem_addr(mem_addr), .done(done), .mode_out(mode_out), .family_out(family_out),
  .ea_out(ea_out), .imm_out(imm_out), .imm_vld(imm_vld), .bit_out(bit_out),
  .br_tgt(br_tgt), .len_out(len_out), .form_err(form_err));
